// [verilog/uart_pkg.sv]
// Shared constants, enumerations and carrier types for the serial port
package uart_pkg;
	// Baud timer
	localparam logic [7:0] TIMER_TOP = 8'hFF; // Count that overflows on next tick
	localparam logic [7:0] BYTE_RESET = 8'h00; // Reset value of byte-wide registers except the control readback
	// Clock prescalers
	localparam logic [5:0] DIV48_TOP = 6'h2F; // Last count of the divide-by-48 counter
	localparam logic [3:0] DIV12_TOP = 4'hB; // Last count of the divide-by-12 counter
	localparam logic [1:0] DIV4_TOP = 2'h3; // Last count of the divide-by-4 phase
	localparam logic [2:0] OSC8_TOP = 3'h7; // Last count of the oscillator divide-by-8
	// Frame counting
	localparam logic [2:0] LAST_DATA_BIT = 3'h7; // Index of the eighth data bit
	// Control readback after reset, unused bit reads one
	localparam logic [7:0] CTRL_RESET = 8'h40;

	// Baud timer clock source choices
	typedef enum logic [2:0] {
		SRC_SYS = 3'h0,
		SRC_DIV4 = 3'h1,
		SRC_DIV12 = 3'h2,
		SRC_DIV48 = 3'h3,
		SRC_OSC8 = 3'h4,
		SRC_EXT = 3'h5
	} clk_src_t;

	// Software control bits of the port
	typedef struct packed {
		logic frame_width_select; // 0: 8-bit frames, 1: 9-bit frames
		logic multiproc_filter_enable; // Stop-bit or ninth-bit filter
		logic rx_enable_bit; // Receiver may start frames
		logic tx_ninth_bit; // Ninth bit sent in 9-bit mode
	} serial_ctrl_t;

	// Baud timer setup
	typedef struct packed {
		logic run; // Timer enabled
		clk_src_t src; // Timer clock source
		logic [7:0] reload; // Auto-reload byte
	} timer_cfg_t;

	// Transmitter states, Gray along the 9-bit path
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_LOAD = 3'h1,
		TX_START = 3'h3,
		TX_DATA = 3'h2,
		TX_NINTH = 3'h6,
		TX_STOP = 3'h7
	} tx_state_t;

	// Receiver states, Gray along the 9-bit path
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_NINTH = 3'h2,
		RX_STOP = 3'h6
	} rx_state_t;
endpackage : uart_pkg

// [verilog/baud_timer.sv]
// Eight-bit auto-reload timer with divide-by-two bit tick
`timescale 1ns/1ps
module baud_timer (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Timer control
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic i_force_reload,
	input wire logic [7:0] i_reload_byte,
	// Timer results
	output logic [7:0] o_count,
	output logic o_overflow,
	output logic o_bit_tick
);
	logic [7:0] count_reg; // Up counter
	logic [7:0] count_next;
	logic half_reg; // Overflow pair phase
	logic half_next;
	logic wrap; // Counter passes the top this cycle

	// Overflow and divide-by-two decode
	assign wrap = i_run && i_tick && (count_reg == uart_pkg::TIMER_TOP) && !i_force_reload;
	assign o_overflow = wrap;
	assign o_bit_tick = wrap && !half_reg;
	assign o_count = count_reg;

	// Reload wins, then wrap reload, then count
	assign count_next = i_force_reload ? i_reload_byte :
		wrap ? i_reload_byte :
		(i_run && i_tick) ? count_reg + 8'h01 : count_reg;
	assign half_next = i_force_reload ? 1'b0 : (wrap ? !half_reg : half_reg);

	// Timer registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			count_reg <= uart_pkg::BYTE_RESET;
			half_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			half_reg <= half_next;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	// Overflow reloads the count from the reload byte
	AST_TIMER_RELOAD: assert property (o_overflow |=> count_reg == $past(i_reload_byte))
		else $error("timer did not reload after overflow");
	// Two overflows give one bit tick
	AST_TIMER_HALF: assert property (o_bit_tick |=> half_reg)
		else $error("bit tick did not advance the half phase");
	// Forced reload restarts from the reload byte
	AST_TIMER_FORCE: assert property (i_force_reload |=> count_reg == $past(i_reload_byte) && !half_reg)
		else $error("forced reload not taken");
endmodule : baud_timer

// [verilog/serial_port_zero.sv]
// Serial port: transmitter, double-buffered receiver, baud timers and clock select
`timescale 1ns/1ps
// Contract
// - Buffer writes load the transmit register while idle, dropped while busy
// - Buffer reads return the receive latch only
// - Enabled port requests interrupt on either flag
// - Done flags cleared only by software
// - Receiver double-buffered, shifts while latch held
// - Transmit timing from 8-bit auto-reload timer
// - Hidden receive timer, same reload byte
// - Timer overflows divided by two per direction
// - Overflow every 256 minus reload counts
// - Start detection reloads the receive timer
// - Timer clock from six selectable sources
// - Control bit seven selects frame width
// - 8-bit frame: start, eight LSB-first, stop
// - 8-bit mode stores stop bit as ninth
// - Write starts sending; done flag at stop
// - Receive only after receive enable set
// - 8-bit load needs clear flag, filtered stop
// - Overrun keeps first byte, drops later bits
// - 9-bit frame adds programmable ninth bit
// - Sent ninth bit follows control bit three
// - 9-bit mode stores ninth, ignores stop
// - 9-bit load needs clear flag, filtered ninth
// - Filter enable sits at control bit five
// - Receive flag set when stop is sampled
module serial_port_zero (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// Control bits and interrupt enable
	input wire uart_pkg::serial_ctrl_t i_ctrl,
	input wire logic i_irq_enable,
	// Baud timer setup and external clock sources
	input wire uart_pkg::timer_cfg_t i_timer_cfg,
	input wire logic i_ext_osc_tick,
	input wire logic i_baud_timer_ext_input,
	// Data buffer access
	input wire logic i_buf_wr,
	input wire logic [7:0] i_buf_wdata,
	output logic [7:0] o_rx_data,
	// Flag clears from software
	input wire logic i_tx_done_clr,
	input wire logic i_rx_done_clr,
	// Status
	output logic o_tx_done_flag,
	output logic o_rx_done_flag,
	output logic o_rx_ninth_bit,
	output logic o_irq,
	output logic o_tx_busy,
	output logic [7:0] o_serial_control_reg,
	// Serial pins
	input wire logic i_serial_in_pin,
	output logic o_serial_out_pin
);
	// Prescaler state
	logic [5:0] div48_reg; // Divide-by-48 counter, low bits give divide-by-4
	logic [5:0] div48_next;
	logic [3:0] div12_reg; // Divide-by-12 counter
	logic [3:0] div12_next;
	logic [2:0] osc8_reg; // Oscillator tick divider
	logic [2:0] osc8_next;
	logic ext_prev_reg; // Last external input level
	logic timer_tick; // Selected timer clock enable
	// Timer outputs
	logic tx_bit_tick; // One transmit bit period
	logic rx_bit_tick; // One receive bit period, mid-bit after start
	logic [7:0] rx_timer_count; // Receive timer count
	logic [7:0] reload_byte; // Reload byte for both timers
	// Transmitter state
	uart_pkg::tx_state_t tx_state_reg;
	uart_pkg::tx_state_t tx_state_next;
	logic [7:0] tx_shift_reg; // Transmit register
	logic [7:0] tx_shift_next;
	logic [2:0] tx_cnt_reg; // Data bit index
	logic [2:0] tx_cnt_next;
	logic tx_line_reg; // Serial output level
	logic tx_line_next;
	logic tx_enter_stop; // Stop bit begins
	// Receiver state
	uart_pkg::rx_state_t rx_state_reg;
	uart_pkg::rx_state_t rx_state_next;
	logic [7:0] rx_shift_reg; // Receive shifter
	logic [7:0] rx_shift_next;
	logic [2:0] rx_cnt_reg;
	logic [2:0] rx_cnt_next;
	logic rx_bit9_reg; // Received ninth data bit
	logic rx_bit9_next;
	logic rx_prev_reg; // Last input level for edge detect
	logic rx_start_detect; // Falling edge on an idle, enabled receiver
	logic rx_stop_sample; // Stop bit sampled now
	logic rx_check_bit; // Bit the filter inspects
	logic rx_load; // Frame accepted into the latch
	// Latch, flags and outputs
	logic [7:0] rx_data_reg;
	logic [7:0] rx_data_next;
	logic rx_ninth_reg;
	logic rx_ninth_next;
	logic tx_done_reg;
	logic tx_done_next;
	logic rx_done_reg;
	logic rx_done_next;
	logic irq_reg;
	logic irq_next;
	logic busy_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;

	// Prescaler counters
	assign div48_next = (div48_reg == uart_pkg::DIV48_TOP) ? 6'h00 : div48_reg + 6'h01;
	assign div12_next = (div12_reg == uart_pkg::DIV12_TOP) ? 4'h0 : div12_reg + 4'h1;
	assign osc8_next = i_ext_osc_tick ? osc8_reg + 3'h1 : osc8_reg;

	// Timer clock source select
	assign timer_tick =
		(i_timer_cfg.src == uart_pkg::SRC_SYS) ? 1'b1 :
		(i_timer_cfg.src == uart_pkg::SRC_DIV4) ? (div48_reg[1:0] == uart_pkg::DIV4_TOP) :
		(i_timer_cfg.src == uart_pkg::SRC_DIV12) ? (div12_reg == uart_pkg::DIV12_TOP) :
		(i_timer_cfg.src == uart_pkg::SRC_DIV48) ? (div48_reg == uart_pkg::DIV48_TOP) :
		(i_timer_cfg.src == uart_pkg::SRC_OSC8) ? (i_ext_osc_tick && osc8_reg == uart_pkg::OSC8_TOP) :
		(i_timer_cfg.src == uart_pkg::SRC_EXT) ? (ext_prev_reg && !i_baud_timer_ext_input) :
		1'b0;
	assign reload_byte = i_timer_cfg.reload;

	// Prescaler registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			div48_reg <= 6'h00;
			div12_reg <= 4'h0;
			osc8_reg <= 3'h0;
			ext_prev_reg <= 1'b1;
		end else begin
			div48_reg <= div48_next;
			div12_reg <= div12_next;
			osc8_reg <= osc8_next;
			ext_prev_reg <= i_baud_timer_ext_input;
		end
	end

	// Transmit timer, free running phase
	baud_timer u_tx_timer (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_run(i_timer_cfg.run),
		.i_tick(timer_tick),
		.i_force_reload(1'b0),
		.i_reload_byte(reload_byte),
		.o_count(),
		.o_overflow(),
		.o_bit_tick(tx_bit_tick)
	);

	// Receive timer, restarted by each start edge
	baud_timer u_rx_timer (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_run(i_timer_cfg.run),
		.i_tick(timer_tick),
		.i_force_reload(rx_start_detect),
		.i_reload_byte(reload_byte),
		.o_count(rx_timer_count),
		.o_overflow(),
		.o_bit_tick(rx_bit_tick)
	);

	// Transmitter sequence
	always_comb begin
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_line_next = tx_line_reg;
		case (tx_state_reg)
			uart_pkg::TX_IDLE: begin
				tx_line_next = 1'b1;
				if (i_buf_wr) begin
					tx_shift_next = i_buf_wdata;
					tx_state_next = uart_pkg::TX_LOAD;
				end
			end
			uart_pkg::TX_LOAD: if (tx_bit_tick) begin
				tx_line_next = 1'b0;
				tx_state_next = uart_pkg::TX_START;
			end
			uart_pkg::TX_START: if (tx_bit_tick) begin
				tx_line_next = tx_shift_reg[0];
				tx_cnt_next = 3'h0;
				tx_state_next = uart_pkg::TX_DATA;
			end
			uart_pkg::TX_DATA: if (tx_bit_tick) begin
				if (tx_cnt_reg == uart_pkg::LAST_DATA_BIT) begin
					if (i_ctrl.frame_width_select) begin
						tx_line_next = i_ctrl.tx_ninth_bit;
						tx_state_next = uart_pkg::TX_NINTH;
					end else begin
						tx_line_next = 1'b1;
						tx_state_next = uart_pkg::TX_STOP;
					end
				end else begin
					tx_shift_next = {1'b0, tx_shift_reg[7:1]};
					tx_line_next = tx_shift_reg[1];
					tx_cnt_next = tx_cnt_reg + 3'h1;
				end
			end
			uart_pkg::TX_NINTH: if (tx_bit_tick) begin
				tx_line_next = 1'b1;
				tx_state_next = uart_pkg::TX_STOP;
			end
			uart_pkg::TX_STOP: if (tx_bit_tick) begin
				tx_state_next = uart_pkg::TX_IDLE;
			end
			default: begin
				tx_line_next = 1'b1;
				tx_state_next = uart_pkg::TX_IDLE;
			end
		endcase
	end
	assign tx_enter_stop = (tx_state_next == uart_pkg::TX_STOP) && (tx_state_reg != uart_pkg::TX_STOP);

	// Receiver decode
	assign rx_start_detect = (rx_state_reg == uart_pkg::RX_IDLE) && i_ctrl.rx_enable_bit &&
		rx_prev_reg && !i_serial_in_pin;
	assign rx_stop_sample = (rx_state_reg == uart_pkg::RX_STOP) && rx_bit_tick;
	assign rx_check_bit = i_ctrl.frame_width_select ? rx_bit9_reg : i_serial_in_pin;
	assign rx_load = rx_stop_sample && !rx_done_reg &&
		(!i_ctrl.multiproc_filter_enable || rx_check_bit);

	// Receiver sequence, shifter separate from the latch
	always_comb begin
		rx_state_next = rx_state_reg;
		rx_shift_next = rx_shift_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_bit9_next = rx_bit9_reg;
		case (rx_state_reg)
			uart_pkg::RX_IDLE: if (rx_start_detect) begin
				rx_state_next = uart_pkg::RX_START;
			end
			uart_pkg::RX_START: if (rx_bit_tick) begin
				// High at mid start is a glitch, not a frame
				rx_cnt_next = 3'h0;
				rx_state_next = i_serial_in_pin ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
			end
			uart_pkg::RX_DATA: if (rx_bit_tick) begin
				rx_shift_next = {i_serial_in_pin, rx_shift_reg[7:1]};
				rx_cnt_next = rx_cnt_reg + 3'h1;
				if (rx_cnt_reg == uart_pkg::LAST_DATA_BIT) begin
					rx_state_next = i_ctrl.frame_width_select ? uart_pkg::RX_NINTH :
						uart_pkg::RX_STOP;
				end
			end
			uart_pkg::RX_NINTH: if (rx_bit_tick) begin
				rx_bit9_next = i_serial_in_pin;
				rx_state_next = uart_pkg::RX_STOP;
			end
			uart_pkg::RX_STOP: if (rx_bit_tick) begin
				rx_state_next = uart_pkg::RX_IDLE;
			end
			default: rx_state_next = uart_pkg::RX_IDLE;
		endcase
	end

	// Latch, flags, interrupt and readback next values
	assign rx_data_next = rx_load ? rx_shift_reg : rx_data_reg;
	assign rx_ninth_next = rx_load ? rx_check_bit : rx_ninth_reg;
	assign tx_done_next = tx_enter_stop || (tx_done_reg && !i_tx_done_clr);
	assign rx_done_next = rx_load || (rx_done_reg && !i_rx_done_clr);
	assign irq_next = i_irq_enable && (tx_done_next || rx_done_next);
	assign ctrl_next = {i_ctrl.frame_width_select, 1'b1, i_ctrl.multiproc_filter_enable,
		i_ctrl.rx_enable_bit, i_ctrl.tx_ninth_bit, rx_ninth_next, tx_done_next, rx_done_next};

	// State registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			tx_state_reg <= uart_pkg::TX_IDLE;
			tx_shift_reg <= uart_pkg::BYTE_RESET;
			tx_cnt_reg <= 3'h0;
			tx_line_reg <= 1'b1;
			rx_state_reg <= uart_pkg::RX_IDLE;
			rx_shift_reg <= uart_pkg::BYTE_RESET;
			rx_cnt_reg <= 3'h0;
			rx_bit9_reg <= 1'b0;
			rx_prev_reg <= 1'b1;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_shift_reg <= tx_shift_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_line_reg <= tx_line_next;
			rx_state_reg <= rx_state_next;
			rx_shift_reg <= rx_shift_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bit9_reg <= rx_bit9_next;
			rx_prev_reg <= i_serial_in_pin;
		end
	end

	// Software-visible registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			rx_data_reg <= uart_pkg::BYTE_RESET;
			rx_ninth_reg <= 1'b0;
			tx_done_reg <= 1'b0;
			rx_done_reg <= 1'b0;
			irq_reg <= 1'b0;
			busy_reg <= 1'b0;
			ctrl_reg <= uart_pkg::CTRL_RESET;
		end else begin
			rx_data_reg <= rx_data_next;
			rx_ninth_reg <= rx_ninth_next;
			tx_done_reg <= tx_done_next;
			rx_done_reg <= rx_done_next;
			irq_reg <= irq_next;
			busy_reg <= (tx_state_next != uart_pkg::TX_IDLE);
			ctrl_reg <= ctrl_next;
		end
	end

	// Outputs straight from registers
	assign o_rx_data = rx_data_reg;
	assign o_rx_ninth_bit = rx_ninth_reg;
	assign o_tx_done_flag = tx_done_reg;
	assign o_rx_done_flag = rx_done_reg;
	assign o_irq = irq_reg;
	assign o_tx_busy = busy_reg;
	assign o_serial_control_reg = ctrl_reg;
	assign o_serial_out_pin = tx_line_reg;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	AST_TX_IDLE_HIGH: assert property (tx_state_reg == uart_pkg::TX_IDLE |-> o_serial_out_pin)
		else $error("line not high while idle");
	AST_TX_START_LOW: assert property (tx_state_reg == uart_pkg::TX_START |-> !o_serial_out_pin)
		else $error("start bit not low");
	AST_TX_DONE_AT_STOP: assert property ($rose(tx_state_reg == uart_pkg::TX_STOP) |-> o_tx_done_flag)
		else $error("transmit flag missing at stop");
	AST_TX_FLAG_HOLD: assert property (o_tx_done_flag && !i_tx_done_clr |=> o_tx_done_flag)
		else $error("transmit flag lost without clear");
	AST_RX_OVERRUN: assert property (o_rx_done_flag && !i_rx_done_clr |=> o_rx_done_flag && $stable(o_rx_data))
		else $error("receive latch changed while flag set");
	AST_IRQ: assert property (o_irq == ($past(i_irq_enable) && (o_tx_done_flag || o_rx_done_flag)))
		else $error("interrupt does not follow flags");
	AST_RX_GATE: assert property (!i_ctrl.rx_enable_bit && rx_state_reg == uart_pkg::RX_IDLE |=> rx_state_reg == uart_pkg::RX_IDLE)
		else $error("receiver started while disabled");
	AST_RX_RELOAD: assert property (rx_start_detect |=> rx_timer_count == $past(reload_byte))
		else $error("start edge did not reload receive timer");
	AST_RX_FILTER: assert property ($rose(o_rx_done_flag) && $past(i_ctrl.multiproc_filter_enable) |-> o_rx_ninth_bit)
		else $error("filtered frame accepted with low check bit");
	AST_RX_AT_STOP: assert property ($rose(o_rx_done_flag) |-> $past(rx_stop_sample))
		else $error("receive flag set outside stop sampling");

	COV_TX_NINE: cover property (tx_state_reg == uart_pkg::TX_NINTH ##[1:300] tx_state_reg == uart_pkg::TX_STOP);
	COV_RX_LOAD: cover property (rx_load);
	COV_RX_OVERRUN: cover property (rx_stop_sample && o_rx_done_flag);
	COV_RX_FILTERED: cover property (rx_stop_sample && !o_rx_done_flag && !rx_load);
endmodule : serial_port_zero

// [bench/serial_partner.sv]
// Remote serial transceiver model that drives and decodes the line
`timescale 1ns/1ps
module serial_partner (
	// Clock
	input wire logic i_ref_clk,
	// Line from the port
	input wire logic i_serial_out_pin,
	// Line into the port
	output logic o_serial_in_pin
);
	// Line rests high between frames
	initial o_serial_in_pin = 1'b1;

	// Sends start, data LSB first, optional ninth, stop, then rests idle
	task automatic send_frame(input logic [7:0] d, input logic nine, input logic b9,
		input logic stp, input int t);
		logic [10:0] bits;
		int n;
		int i;
		bits = {stp, b9, d, 1'b0};
		n = nine ? 11 : 10;
		if (!nine) bits[9] = stp;
		for (i = 0; i < n; i++) begin
			@(negedge i_ref_clk);
			o_serial_in_pin = bits[i];
			repeat (t - 1) @(negedge i_ref_clk);
		end
		@(negedge i_ref_clk);
		o_serial_in_pin = 1'b1;
		repeat (t) @(negedge i_ref_clk);
	endtask : send_frame

	// Decodes one frame; data bit 0 must be one so the start width is exact
	task automatic capture(input int t, input logic nine, output logic [9:0] w,
		output int width);
		int i;
		w = '0;
		width = 0;
		i = 0;
		while (i < 20000 && i_serial_out_pin !== 1'b0) begin
			@(negedge i_ref_clk);
			i++;
		end
		while (width < 20000 && i_serial_out_pin === 1'b0) begin
			@(negedge i_ref_clk);
			width++;
		end
		w[0] = 1'b1;
		for (i = 1; i < (nine ? 10 : 9); i++) begin
			repeat ((i == 1) ? t + t / 2 : t) @(negedge i_ref_clk);
			w[i] = i_serial_out_pin;
		end
	endtask : capture
endmodule : serial_partner

// [bench/serial_port_zero_tb.sv]
// Self-checking bench for the serial port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module serial_port_zero_tb;
	// Stimulus and observed signals
	logic clk;
	logic nrst;
	uart_pkg::serial_ctrl_t ctrl;
	uart_pkg::timer_cfg_t cfg;
	logic irq_en, buf_wr, tx_clr, rx_clr, line_in;
	logic [7:0] wdata, rx_data, ctrl_rb;
	logic tx_done, rx_done, rx9, irq, busy, line_out;
	logic ext_tgl = 1'b0; // Shared external tick source, toggles every cycle
	int n_fail = 0;
	int cmp_count = 0;
	localparam int T = 8; // Bit period for reload FC at the system clock

	// Design under test, external tick inputs fed by the toggle
	serial_port_zero i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_ctrl(ctrl),
		.i_irq_enable(irq_en), .i_timer_cfg(cfg), .i_ext_osc_tick(ext_tgl),
		.i_baud_timer_ext_input(ext_tgl), .i_buf_wr(buf_wr), .i_buf_wdata(wdata),
		.o_rx_data(rx_data), .i_tx_done_clr(tx_clr), .i_rx_done_clr(rx_clr),
		.o_tx_done_flag(tx_done), .o_rx_done_flag(rx_done), .o_rx_ninth_bit(rx9),
		.o_irq(irq), .o_tx_busy(busy), .o_serial_control_reg(ctrl_rb),
		.i_serial_in_pin(line_in), .o_serial_out_pin(line_out));
	// Far-side transceiver
	serial_partner i_far (.i_ref_clk(clk), .i_serial_out_pin(line_out),
		.o_serial_in_pin(line_in));

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// External ticks: oscillator pulse every 2 cycles, input falls every 2 cycles
	always @(negedge clk) ext_tgl <= ~ext_tgl;

	// Verdict and end of run
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// One-cycle buffer write
	task automatic wr_byte(input logic [7:0] d);
		@(negedge clk);
		buf_wr = 1'b1;
		wdata = d;
		@(negedge clk);
		buf_wr = 1'b0;
	endtask : wr_byte

	// Pulse both flag clears
	task automatic clr_flags();
		@(negedge clk);
		tx_clr = 1'b1;
		rx_clr = 1'b1;
		@(negedge clk);
		tx_clr = 1'b0;
		rx_clr = 1'b0;
	endtask : clr_flags

	// Transmit from all six timer clock sources, with a write dropped while busy
	task automatic test_tx_rates();
		logic [9:0] w;
		int width, k, i;
		// Oscillator source: tick every 2 cycles divided by 8; external: fall every 2
		int mult [6] = '{1, 4, 12, 48, 16, 2};
		uart_pkg::clk_src_t src [6] = '{uart_pkg::SRC_SYS, uart_pkg::SRC_DIV4,
			uart_pkg::SRC_DIV12, uart_pkg::SRC_DIV48, uart_pkg::SRC_OSC8, uart_pkg::SRC_EXT};
		for (k = 0; k < 6; k++) begin
			cfg.src = src[k];
			// Watch the line before the write so the whole start bit is seen
			fork
				i_far.capture(T * mult[k], 1'b0, w, width);
				begin
					wr_byte(8'hA5);
					wr_byte(8'h5A);
				end
			join
			`CHK("start width", T * mult[k], width)
			`CHK("tx frame", 9'h1A5, w[8:0])
			`CHK("tx flag", 1'b1, tx_done)
			`CHK("irq", 1'b1, irq)
			`CHK("tx busy", 1'b1, busy)
			i = 0;
			while (i < 2000 && busy !== 1'b0) begin
				@(negedge clk);
				i++;
			end
			repeat (2 * T * mult[k]) @(negedge clk);
			`CHK("tx busy idle", 1'b0, busy)
			`CHK("line idle", 1'b1, line_out)
			`CHK("tx flag held", 1'b1, tx_done)
			clr_flags();
			`CHK("tx flag cleared", 1'b0, tx_done)
			`CHK("irq cleared", 1'b0, irq)
		end
		cfg.src = uart_pkg::SRC_SYS;
	endtask : test_tx_rates

	// Nine-bit frames carry the software ninth bit
	task automatic test_tx_nine();
		logic [9:0] w;
		int width, b;
		ctrl.frame_width_select = 1'b1;
		for (b = 0; b < 2; b++) begin
			ctrl.tx_ninth_bit = b[0];
			wr_byte(8'hA5);
			i_far.capture(T, 1'b1, w, width);
			`CHK("tx9 frame", {1'b1, b[0], 8'hA5}, w)
			`CHK("tx9 flag", 1'b1, tx_done)
			repeat (3 * T) @(negedge clk);
			clr_flags();
		end
		ctrl = '0;
	endtask : test_tx_nine

	// Eight-bit receive: enable, stop storage, overrun and stop filter
	task automatic test_rx_eight();
		i_far.send_frame(8'h3C, 1'b0, 1'b0, 1'b1, T);
		`CHK("rx disabled", 1'b0, rx_done)
		ctrl.rx_enable_bit = 1'b1;
		i_far.send_frame(8'h3C, 1'b0, 1'b0, 1'b1, T);
		`CHK("rx data", 8'h3C, rx_data)
		`CHK("rx stop kept", 1'b1, rx9)
		`CHK("rx flag", 1'b1, rx_done)
		`CHK("rx irq", 1'b1, irq)
		i_far.send_frame(8'hC3, 1'b0, 1'b0, 1'b1, T);
		`CHK("overrun data", 8'h3C, rx_data)
		clr_flags();
		`CHK("rx flag cleared", 1'b0, rx_done)
		i_far.send_frame(8'h66, 1'b0, 1'b0, 1'b0, T);
		`CHK("bad stop taken", 8'h66, rx_data)
		`CHK("stop zero kept", 1'b0, rx9)
		clr_flags();
		ctrl.multiproc_filter_enable = 1'b1;
		i_far.send_frame(8'h55, 1'b0, 1'b0, 1'b0, T);
		`CHK("filtered flag", 1'b0, rx_done)
		`CHK("filtered data", 8'h66, rx_data)
	endtask : test_rx_eight

	// Nine-bit receive with the address filter on
	task automatic test_rx_nine();
		ctrl.frame_width_select = 1'b1;
		i_far.send_frame(8'h11, 1'b1, 1'b0, 1'b1, T);
		`CHK("ninth zero refused", 1'b0, rx_done)
		`CHK("refused data", 8'h66, rx_data)
		i_far.send_frame(8'h22, 1'b1, 1'b1, 1'b0, T);
		`CHK("rx9 data", 8'h22, rx_data)
		`CHK("rx ninth", 1'b1, rx9)
		`CHK("ctrl readback", 8'hF5, ctrl_rb)
		clr_flags();
	endtask : test_rx_nine

	// Main sequence
	initial begin
		nrst = 1'b0;
		ctrl = '0;
		cfg = {1'b1, uart_pkg::SRC_SYS, 8'hFC};
		irq_en = 1'b1;
		buf_wr = 1'b0;
		wdata = 8'h00;
		tx_clr = 1'b0;
		rx_clr = 1'b0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		`CHK("reset line", 1'b1, line_out)
		`CHK("reset readback", 8'h40, ctrl_rb)
		test_tx_rates();
		test_tx_nine();
		test_rx_eight();
		test_rx_nine();
		stop_test();
	end

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule : serial_port_zero_tb
